// file: hdl/touch_events.sv
/*
  touch event logic: per-channel debounce, two-key decode, cascade clocking and
  interrupt chain, with an avalon-mm register slave.
  assumes all inputs synchronous to i_clk; the analog front end delivers one
  calibration step pulse per sample with its direction on i_step_up.
*/
// Local design decisions: the Avalon-MM slave port and the register addresses.
`timescale 1ns/100ps
`include "touch_map.svh"

module touch_events
  import touch_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rst_b,
  input  wire logic [3:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic [31:0]      o_avs_readdata,
  output logic             o_avs_waitrequest,
  input  wire logic [7:0]  i_calibration_step_pulse,
  input  wire logic [7:0]  i_step_up,
  input  wire logic        i_address_select_pin,
  input  wire logic        i_osc_ref,
  input  wire logic        i_ext_clk,
  input  wire logic        i_int_chain,
  output logic             o_int,
  output logic             o_clk_out,
  output logic             o_osc_enable,
  output logic             o_ref_clk,
  output logic [6:0]       o_i2c_addr,
  output logic [7:0]       o_switch,
  output logic [4:0]       o_key_code
);

  // ==========================================================
  // functions
  function automatic logic [4:0] pair_code(input logic [7:0] s);
    logic [4:0] n;
    logic [4:0] code;
    n = 5'h00;
    code = 5'h00;
    for (int i = 0; i < 8; i++) begin
      for (int j = i + 1; j < 8; j++) begin
        n = n + 5'h01;
        if (s == ((8'h01 << i) | (8'h01 << j))) begin
          code = n;
        end
      end
    end
    return code;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] be);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    return (old & ~m) | (wd & m);
  endfunction

  // ==========================================================
  // reset release
  logic [1:0] rst_sync;
  logic       rst_n_s;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n_s = rst_sync[1];

  // ==========================================================
  // next state
  state_s      q;
  state_s      n;
  logic [8:0]  evt;
  logic        acc;
  logic        stat_rd;
  logic [31:0] wd_ctrl;
  logic [31:0] wd_mask;

  always_comb begin
    n = q;
    evt = 9'h000;
    acc = (i_avs_read | i_avs_write) & ~q.waitreq;
    stat_rd = acc & i_avs_read & (i_avs_address == `OFS_STATUS);
    wd_ctrl = merge({26'h0, q.ctrl}, i_avs_writedata, i_avs_byteenable);
    wd_mask = merge({23'h0, q.irq_mask}, i_avs_writedata, i_avs_byteenable);

    // debounce: a reversal starts a new run of one
    for (int c = 0; c < 8; c++) begin
      if (i_calibration_step_pulse[c]) begin
        if (i_step_up[c] != q.dir[c]) begin
          n.dir[c] = i_step_up[c];
          n.cnt[c] = 6'h01;
        end else if (q.cnt[c] == `DEB_LAST) begin
          n.cnt[c] = 6'h00;
          n.sw[c] = q.dir[c];
          evt[c] = (q.sw[c] != q.dir[c]) & ~q.ctrl.two_key;
        end else begin
          n.cnt[c] = q.cnt[c] + 6'h01;
        end
      end
    end

    // two-key: other patterns report no sensor
    n.key = q.ctrl.two_key ? pair_code(n.sw) : 5'h00;
    evt[`IRQ_KEY_BIT] = q.ctrl.two_key & (n.key != q.key) & (n.key != 5'h00);

    // strap is taken once, after the reset release
    if (!q.taken) begin
      n.taken = 1'b1;
      n.addr = {`ADDR_BASE, i_address_select_pin};
    end

    // bus slave: one wait cycle, then a single-cycle answer
    n.waitreq = ~((i_avs_read | i_avs_write) & q.waitreq);
    n.rdata = 32'h0;
    if ((i_avs_read | i_avs_write) & q.waitreq & i_avs_read) begin
      case (i_avs_address)
        `OFS_CTRL:       n.rdata = {26'h0, q.ctrl};
        `OFS_STATUS:     n.rdata = {18'h0, q.addr[0], q.key, q.sw};
        `OFS_IRQ_STATUS: n.rdata = {23'h0, q.irq_st};
        `OFS_IRQ_MASK:   n.rdata = {23'h0, q.irq_mask};
        default:         n.rdata = 32'h0;
      endcase
    end
    if (acc & i_avs_write) begin
      case (i_avs_address)
        `OFS_CTRL:       n.ctrl = ctrl_s'(wd_ctrl[5:0]);
        `OFS_IRQ_STATUS: n.irq_st = q.irq_st & ~(i_avs_writedata[8:0] &
                                    {i_avs_byteenable[1], {8{i_avs_byteenable[0]}}});
        `OFS_IRQ_MASK:   n.irq_mask = wd_mask[8:0];
        default:         n.irq_mask = q.irq_mask;
      endcase
    end
    // reading channel status acknowledges; a same-cycle event still wins
    if (stat_rd) begin
      n.irq_st = 9'h000;
    end
    n.irq_st = n.irq_st | evt;

    // cascade clocking and interrupt chain
    n.irq = (|(q.irq_st & q.irq_mask)) | i_int_chain;
    n.osc_en = ~q.ctrl.ext_clk_sel;
    n.ref_clk = q.ctrl.ext_clk_sel ? i_ext_clk : i_osc_ref;
    n.clk_out = i_osc_ref & q.ctrl.clkout_en & ~q.ctrl.ext_clk_sel;
  end

  always_ff @(posedge i_clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      q <= '0;
      q.ctrl <= ctrl_s'(`CTRL_RESET);
      q.irq_mask <= `IRQ_MASK_RESET;
      q.waitreq <= 1'b1;
      q.osc_en <= 1'b1;
    end else begin
      q <= n;
    end
  end

  assign o_avs_readdata = q.rdata;
  assign o_avs_waitrequest = q.waitreq;
  assign o_int = q.irq;
  assign o_clk_out = q.clk_out;
  assign o_osc_enable = q.osc_en;
  assign o_ref_clk = q.ref_clk;
  assign o_i2c_addr = q.addr;
  assign o_switch = q.sw;
  assign o_key_code = q.key;

  // ==========================================================
  // assertions
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!rst_n_s);

  sequence s_status_rd;
    stat_rd && evt == 9'h000;
  endsequence

  sequence s_sw_change;
    $changed(q.sw[0]) && !$past(q.ctrl.two_key) && q.irq_mask[0];
  endsequence

  // any accepted write or a status read may clear or mask a flag
  sequence s_no_clear;
    !stat_rd && !(acc && i_avs_write);
  endsequence

  debounce_switch_a: assert property (
    $changed(q.sw[0]) |-> $past(i_calibration_step_pulse[0]) && $past(q.cnt[0]) == 6'h3F)
    else $error("switch changed without a full run");

  osc_default_a: assert property (
    $rose(rst_n_s) |-> q.ctrl.osc_freq_select == 3'h4)
    else $error("oscillator select not at default after reset");

  addr_pick_a: assert property (
    $rose(q.taken) |-> q.addr[0] == $past(i_address_select_pin))
    else $error("address bit does not follow select pin");

  clk_out_a: assert property (
    o_clk_out |-> $past(i_osc_ref) && $past(q.ctrl.clkout_en) && !$past(q.ctrl.ext_clk_sel))
    else $error("clock output driven while not enabled");

  ext_clk_a: assert property (
    $past(q.ctrl.ext_clk_sel) |-> !o_osc_enable && o_ref_clk == $past(i_ext_clk))
    else $error("external clock mode left oscillator running");

  int_chain_a: assert property (
    i_int_chain |=> o_int)
    else $error("chain interrupt not passed on");

  two_key_a: assert property (
    q.ctrl.two_key && $countones(n.sw) != 2 |=> q.key == 5'h00)
    else $error("key reported without exactly two inputs");

  pair_order_a: assert property (
    q.ctrl.two_key && n.sw == 8'h81 |=> q.key == 5'h07)
    else $error("pair of inputs 0 and 7 is not sensor 7");

  change_raise_a: assert property (
    s_sw_change ##0 s_no_clear |=> o_int [*2])
    else $error("switch change did not raise interrupt");

  read_clear_a: assert property (
    s_status_rd |=> q.irq_st == 9'h000)
    else $error("status read did not clear interrupt flags");

  // ==========================================================
  // bus, strap, debounce, two-key, interrupt and clock assertions
  // a request seen while waiting is answered on the very next edge
  bus_answer_a: assert property (
    (i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
    else $error("bus request not answered after one wait cycle");

  bus_single_a: assert property (
    !o_avs_waitrequest |=> o_avs_waitrequest)
    else $error("bus answer stood for more than one cycle");

  rdata_idle_a: assert property (
    o_avs_waitrequest |-> o_avs_readdata == 32'h0)
    else $error("read data not zero outside an answer");

  status_read_a: assert property (
    i_avs_read && o_avs_waitrequest && i_avs_address == `OFS_STATUS
    |=> o_avs_readdata[7:0] == $past(q.sw))
    else $error("status read does not show switch state");

  ctrl_write_a: assert property (
    acc && i_avs_write && i_avs_address == `OFS_CTRL && i_avs_byteenable == 4'hF
    |=> q.ctrl == ctrl_s'($past(i_avs_writedata[5:0])))
    else $error("control write did not land");

  strap_hold_a: assert property (
    q.taken |=> $stable(q.addr))
    else $error("bus address moved after strap capture");

  addr_base_a: assert property (
    q.taken |-> o_i2c_addr[6:1] == `ADDR_BASE)
    else $error("bus address upper bits wrong");

  run_restart_a: assert property (
    i_calibration_step_pulse[0] && i_step_up[0] != q.dir[0]
    |=> q.cnt[0] == 6'h01 && q.sw[0] == $past(q.sw[0]))
    else $error("reversal did not restart the run");

  run_idle_a: assert property (
    !i_calibration_step_pulse[0] |=> $stable(q.cnt[0]) && $stable(q.sw[0]))
    else $error("run moved without a step pulse");

  run_dir_a: assert property (
    $changed(q.sw[0]) |-> q.sw[0] == $past(q.dir[0]))
    else $error("switch took a direction other than the run");

  key_direct_a: assert property (
    !q.ctrl.two_key |=> q.key == 5'h00)
    else $error("key code reported outside two-key mode");

  key_flag_a: assert property (
    q.ctrl.two_key && n.key != q.key && n.key != 5'h00 |=> q.irq_st[`IRQ_KEY_BIT])
    else $error("new sensor did not set its flag");

  key_quiet_a: assert property (
    q.ctrl.two_key && q.irq_st[7:0] == 8'h00 |=> q.irq_st[7:0] == 8'h00)
    else $error("channel flag set in two-key mode");

  flag_raise_a: assert property (
    q.irq_st[0] && q.irq_mask[0] |=> o_int)
    else $error("unmasked flag did not raise interrupt");

  int_quiet_a: assert property (
    !i_int_chain && (q.irq_st & q.irq_mask) == 9'h000 |=> !o_int)
    else $error("interrupt raised with nothing pending");

  flag_sticky_a: assert property (
    s_no_clear ##0 q.irq_st[0] |=> q.irq_st[0])
    else $error("channel flag cleared without host action");

  osc_run_a: assert property (
    !q.ctrl.ext_clk_sel |=> o_osc_enable && o_ref_clk == $past(i_osc_ref))
    else $error("internal oscillator not selected");

  clk_out_on_a: assert property (
    q.ctrl.clkout_en && !q.ctrl.ext_clk_sel && i_osc_ref |=> o_clk_out)
    else $error("enabled clock output not driven");

  clk_out_off_a: assert property (
    q.ctrl.ext_clk_sel |=> !o_clk_out)
    else $error("clock output driven in external clock mode");

endmodule

// file: hdl/touch_map.svh
/*
  register offsets, field positions, reset values and counts of the touch event block.
  assumes a 32-bit avalon-mm slave with byte addresses and one word per register.
*/
// What this block does
// - switch state flips only after 64 same-direction calibration pulses in one run
// - oscillator frequency select resets to code 100, internal rc at 80 khz
// - bus address low bit follows the address select pin level
// - primary runs internal oscillator and drives it out when clock output enabled
// - external clock mode clocks logic from clock input, internal oscillator off
// - interrupt output is own interrupt ored with interrupt chain input
// - two-key mode reports a touch only when exactly two inputs are active
// - two-key sensor numbers follow input pairs in lexicographic order, 1 to 28
`ifndef TOUCH_MAP_SVH
`define TOUCH_MAP_SVH

// ==========================================================
// register offsets (byte addresses)
`define OFS_CTRL       4'h0
`define OFS_STATUS     4'h4
`define OFS_IRQ_STATUS 4'h8
`define OFS_IRQ_MASK   4'hC

// ==========================================================
// control fields
`define CTRL_FREQ_LSB    0
`define CTRL_EXT_CLK_BIT 3
`define CTRL_CLKOUT_BIT  4
`define CTRL_TWO_KEY_BIT 5
`define CTRL_RESET       6'h04
`define FREQ_RC_80K      3'h4

// ==========================================================
// status fields and interrupt layout
`define STAT_SW_LSB      0
`define STAT_KEY_LSB     8
`define STAT_ADDR_BIT    13
`define IRQ_KEY_BIT      8
`define IRQ_MASK_RESET   9'h1FF

// ==========================================================
// counts and address
`define DEB_LAST         6'h3F
`define ADDR_BASE        6'h20

`endif

// file: hdl/touch_pkg.sv
/*
  types of the touch event block.
  assumes touch_map.svh for every numeric value.
*/
package touch_pkg;

  typedef struct packed {
    logic       two_key;
    logic       clkout_en;
    logic       ext_clk_sel;
    logic [2:0] osc_freq_select;
  } ctrl_s;

  typedef struct packed {
    ctrl_s           ctrl;
    logic [7:0]      sw;
    logic [7:0]      dir;
    logic [7:0][5:0] cnt;
    logic [4:0]      key;
    logic [8:0]      irq_st;
    logic [8:0]      irq_mask;
    logic            taken;
    logic [6:0]      addr;
    logic            waitreq;
    logic [31:0]     rdata;
    logic            irq;
    logic            clk_out;
    logic            osc_en;
    logic            ref_clk;
  } state_s;

endpackage

// file: tb/cascaded_touch_matrix_events_bench.sv
/*
  self-checking bench of the touch event block.
  assumes the design in hdl/ and the far side model in tb/.
*/
`timescale 1ns/100ps
`include "touch_map.svh"
module cascaded_touch_matrix_events_bench;
  import touch_pkg::*;
  // ==========================================================
  // signals
  logic        i_clk = 0, i_rst_b = 0, rd = 0, wr = 0, strap = 0;
  logic        osc = 0, ext = 0, chain = 0, run = 0, up = 0;
  logic [3:0]  adr = 4'h0;
  logic [31:0] wd = 32'h0, rdata;
  logic [7:0]  sel = 8'h00, pulse, dir, sw;
  logic        waitreq, int_o, clk_out, osc_en, ref_clk;
  logic [6:0]  addr;
  logic [4:0]  key;
  logic [31:0] q[$];
  int          failures = 0, tests_run = 0, cyc = 0, seed = 88609, i, j, n;
  always #10 i_clk = ~i_clk;
  touch_far_model far (.i_clk(i_clk), .i_sel(sel), .i_up(up), .i_run(run),
    .o_pulse(pulse), .o_up(dir));
  touch_events uut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_avs_address(adr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(4'hF),
    .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq),
    .i_calibration_step_pulse(pulse), .i_step_up(dir), .i_address_select_pin(strap),
    .i_osc_ref(osc), .i_ext_clk(ext), .i_int_chain(chain), .o_int(int_o),
    .o_clk_out(clk_out), .o_osc_enable(osc_en), .o_ref_clk(ref_clk),
    .o_i2c_addr(addr), .o_switch(sw), .o_key_code(key));
  // ==========================================================
  // tasks
  task automatic check(string nm, logic [31:0] e, logic [31:0] g);
    tests_run++;
    if (e !== g) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      failures++;
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic bus(logic w, logic [3:0] a, logic [31:0] d);
    rd <= !w; wr <= w; adr <= a; wd <= d;
    @(posedge i_clk);
    while (waitreq !== 1'b0) @(posedge i_clk);
    rd <= 0; wr <= 0;
    @(posedge i_clk);
  endtask
  task automatic read(logic [3:0] a, logic [31:0] e);
    q.push_back(e);
    bus(0, a, 32'h0);
  endtask
  task automatic steps(logic [7:0] s, logic u, int cnt);
    sel <= s; up <= u; run <= 1;
    repeat (cnt) @(posedge i_clk);
    run <= 0;
    repeat (3) @(posedge i_clk);
  endtask
  // ==========================================================
  // watcher: a read answer is taken off the queue at the edge it is sampled
  always @(posedge i_clk) begin
    cyc++;
    if (rd && waitreq === 1'b0) check("readdata", q.pop_front(), rdata);
    if (cyc > 20000) begin
      failures++;
      close_out;
    end
  end
  // ==========================================================
  // scenarios
  initial begin
    repeat (20) @(posedge i_clk);
    i_rst_b <= 1;
    repeat (4) @(posedge i_clk);
    check("addr", {`ADDR_BASE, 1'b0}, {25'h0, addr});
    read(`OFS_CTRL, 32'h00000004);
    read(4'h2, 32'h0);
    $display("reset test done");
    steps(8'h01, 1, 63);
    steps(8'h01, 0, 1);
    steps(8'h01, 1, 63);
    check("switch", 32'h0, {24'h0, sw});
    steps(8'h01, 1, 1);
    check("switch", 32'h1, {24'h0, sw});
    check("int", 32'h1, {31'h0, int_o});
    read(`OFS_STATUS, 32'h00000001);
    @(posedge i_clk);
    check("int", 32'h0, {31'h0, int_o});
    bus(1, `OFS_IRQ_MASK, 32'h0);
    steps(8'h01, 0, 64);
    check("int", 32'h0, {31'h0, int_o});
    read(`OFS_IRQ_STATUS, 32'h00000001);
    bus(1, `OFS_IRQ_STATUS, 32'h1);
    read(`OFS_IRQ_STATUS, 32'h0);
    bus(1, `OFS_IRQ_MASK, 32'h1FF);
    chain <= 1;
    repeat (2) @(posedge i_clk);
    check("int", 32'h1, {31'h0, int_o});
    chain <= 0;
    $display("debounce and interrupt test done");
    osc <= 1;
    bus(1, `OFS_CTRL, 32'h14);
    @(posedge i_clk);
    check("clocks", 32'h7, {29'h0, clk_out, osc_en, ref_clk});
    bus(1, `OFS_CTRL, 32'h1C);
    @(posedge i_clk);
    check("clocks", 32'h0, {29'h0, clk_out, osc_en, ref_clk});
    ext <= 1;
    repeat (2) @(posedge i_clk);
    check("clocks", 32'h1, {29'h0, clk_out, osc_en, ref_clk});
    $display("clock test done");
    bus(1, `OFS_CTRL, 32'h24);
    for (n = 0; n < 7; n++) begin
      i = n < 2 ? 0 : n == 2 ? 6 : {$random(seed)} % 7;
      j = n == 0 ? 1 : n < 3 ? 7 : i + 1 + {$random(seed)} % (7 - i);
      steps(8'h01 << i | 8'h01 << j, 1, 64);
      check("key", i * 7 - i * (i - 1) / 2 + j - i, {27'h0, key});
      steps(8'h01 << i | 8'h01 << j, 0, 64);
    end
    steps(8'h07, 1, 64);
    check("key", 32'h0, {27'h0, key});
    $display("two-key test done");
    i_rst_b <= 0; strap <= 1;
    repeat (2) @(posedge i_clk);
    i_rst_b <= 1;
    repeat (4) @(posedge i_clk);
    check("addr", {`ADDR_BASE, 1'b1}, {25'h0, addr});
    $display("second address test done");
    close_out;
  end
endmodule

// file: tb/touch_far_model.sv
/*
  far side model: analog front end giving one calibration step pulse per cycle.
  assumes the bench selects channels and direction and starts or stops a run.
*/
`timescale 1ns/100ps
module touch_far_model (
  input  wire logic       i_clk,
  input  wire logic [7:0] i_sel,
  input  wire logic       i_up,
  input  wire logic       i_run,
  output logic [7:0]      o_pulse,
  output logic [7:0]      o_up
);
  // ==========================================================
  // step pulses
  // unselected channels get the opposite direction, so a stale value never helps
  always_ff @(posedge i_clk) begin
    o_pulse <= i_run ? i_sel : 8'h00;
    o_up    <= i_up ? i_sel : ~i_sel;
  end
endmodule
